// ---- inc/afsc_defines.svh ----
/*
 * holds the offsets, field positions, reset values and opcode patterns of the add-family
 * execute and slot-check block.
 * assumes it is included by its bare name wherever these constants are needed.
 */
`ifndef AFSC_DEFINES_SVH
`define AFSC_DEFINES_SVH

// ----------------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define AFSC_OFS_STATUS_WORD  8'h00
`define AFSC_OFS_EVT_STATUS   8'h04
`define AFSC_OFS_EVT_MASK     8'h08
`define AFSC_OFS_EXC_PC       8'h0c
`define AFSC_OFS_RET_ADDR     8'h10
`define AFSC_OFS_GREG_BASE    8'h40
`define AFSC_GREG_SEL_MASK    8'hc0

// ----------------------------------------------------------------------------
// status word field positions and reset value
// ----------------------------------------------------------------------------
`define AFSC_SW_T        0
`define AFSC_SW_S        1
`define AFSC_SW_RPL      2
`define AFSC_SW_RPH      3
`define AFSC_SW_I_LO     4
`define AFSC_SW_I_HI     7
`define AFSC_SW_Q        8
`define AFSC_SW_M        9
`define AFSC_SW_XMD      10
`define AFSC_SW_YMD      11
`define AFSC_SW_LC_LO    16
`define AFSC_SW_LC_HI    27
`define AFSC_SW_WMASK    32'h0fff_0fff
`define AFSC_SW_RESET    32'h0000_00f0

// ----------------------------------------------------------------------------
// event bits and reset values
// ----------------------------------------------------------------------------
`define AFSC_EVT_ILLEGAL  0
`define AFSC_EVT_SLOT     1
`define AFSC_EVT_LOOP     2
`define AFSC_EVT_OVF      3
`define AFSC_EVT_W        4
`define AFSC_EVT_RESET    4'h0
`define AFSC_WORD_RESET   32'h0000_0000

// ----------------------------------------------------------------------------
// opcode masks and matches
// ----------------------------------------------------------------------------
`define AFSC_M_RR    16'hf00f
`define AFSC_P_ADD   16'h300c
`define AFSC_P_SUMC  16'h300e
`define AFSC_P_SUMV  16'h300f
`define AFSC_M_HI4   16'hf000
`define AFSC_P_ADDI  16'h7000
`define AFSC_P_BRA   16'ha000
`define AFSC_P_BSR   16'hb000
`define AFSC_M_HI8   16'hff00
`define AFSC_P_BT    16'h8900
`define AFSC_P_BF    16'h8b00
`define AFSC_P_BTS   16'h8d00
`define AFSC_P_BFS   16'h8f00
`define AFSC_P_TRAP  16'hc300
`define AFSC_M_REG   16'hf0ff
`define AFSC_P_JMP   16'h402b
`define AFSC_P_JSR   16'h400b
`define AFSC_P_BRAF  16'h0023
`define AFSC_P_BSRF  16'h0003
`define AFSC_P_LDSR  16'h400e
`define AFSC_P_LDSRM 16'h4007
`define AFSC_M_ALL   16'hffff
`define AFSC_P_RTS   16'h000b
`define AFSC_P_RTE   16'h002b
`define AFSC_P_NOP   16'h0009
`define AFSC_PC_AHEAD 32'h0000_0004

`endif

// ---- inc/afsc_pkg.sv ----
/*
 * holds the types of the add-family execute and slot-check block.
 * assumes afsc_defines.svh is on the include path.
 */
package afsc_pkg;

   // ----------------------------------------------------------------------------
   // instruction port and address-unit carriers
   // ----------------------------------------------------------------------------
   typedef struct packed {
      logic        valid;
      logic [15:0] word;
      logic [31:0] pc;
      logic        known_other;
      logic        loop_reg_wr;
      logic        loop_tail;
   } afsc_instr_t;

   typedef struct packed {
      logic        valid;
      logic [31:0] base;
      logic [7:0]  disp;
      logic [1:0]  size;
      logic        pc_rel;
   } afsc_agu_req_t;

   typedef enum logic [1:0] {
      AFSC_CAUSE_NONE    = 2'b00,
      AFSC_CAUSE_ILLEGAL = 2'b01,
      AFSC_CAUSE_SLOT    = 2'b10,
      AFSC_CAUSE_LOOP    = 2'b11
   } afsc_cause_t;

   typedef enum logic {
      AFSC_SLOT_IDLE  = 1'b0,
      AFSC_SLOT_ARMED = 1'b1
   } afsc_slot_t;

endpackage : afsc_pkg

// ---- src/afsc_core.sv ----
/*
 * holds the add-family execute unit with delayed-branch slot checks, repeat-loop tail
 * checks, displacement scaling, a register port and a level interrupt.
 * assumes one 125 MHz clock, instructions presented in order one per valid cycle, and
 * an outer decoder that flags the other assigned opcodes and loop-register writers.
 */
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "afsc_defines.svh"

module afsc_core #(
   parameter int NUM_GREGS = 16
) (
   input  wire logic                 clk,
   input  wire logic                 reset,
   input  wire afsc_pkg::afsc_instr_t   instr,
   input  wire afsc_pkg::afsc_agu_req_t agu_req,
   input  wire logic [7:0]           reg_addr,
   input  wire logic [31:0]          reg_wdata,
   input  wire logic                 reg_wr,
   input  wire logic                 reg_rd,
   output logic [31:0]               reg_rdata,
   output logic                      irq,
   output logic                      redirect_valid,
   output logic [31:0]               redirect_pc,
   output logic                      exc_valid,
   output afsc_pkg::afsc_cause_t     exc_cause,
   output logic [31:0]               exc_pc,
   output logic                      intr_block,
   output logic                      agu_valid,
   output logic [31:0]               agu_addr
);
   import afsc_pkg::*;

   // ----------------------------------------------------------------------------
   // helper functions
   // ----------------------------------------------------------------------------
   function automatic logic match(input logic [15:0] w, input logic [15:0] m, input logic [15:0] p);
      match = ((w & m) == p);
   endfunction : match

   // pc value seen by relative addressing
   function automatic logic [31:0] pc_ahead(input logic [31:0] pc);
      pc_ahead = pc + `AFSC_PC_AHEAD;
   endfunction : pc_ahead

   function automatic logic [31:0] scale_disp(input logic [7:0] d, input logic [1:0] size);
      logic [31:0] z;
      z = {24'h00_0000, d};
      unique case (size)
         2'b00:   scale_disp = z;
         2'b01:   scale_disp = {z[30:0], 1'b0};
         default: scale_disp = {z[29:0], 2'b00};
      endcase
   endfunction : scale_disp

   // ----------------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------------
   logic [31:0]          gregs_r [NUM_GREGS];
   logic [31:0]          status_word_r;
   logic [31:0]          ret_addr_r;
   logic [`AFSC_EVT_W-1:0] evt_status_r;
   logic [`AFSC_EVT_W-1:0] evt_mask_r;
   logic [31:0]          exc_pc_r;
   afsc_slot_t           slot_r;
   logic [31:0]          target_r;
   logic [31:0]          reg_rdata_r;
   logic                 irq_r;
   logic                 redirect_valid_r;
   logic [31:0]          redirect_pc_r;
   logic                 exc_valid_r;
   afsc_cause_t          exc_cause_r;
   logic                 agu_valid_r;
   logic [31:0]          agu_addr_r;

   // ----------------------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------------------
   logic [15:0] w;
   logic [3:0]  rn;
   logic [3:0]  rm;
   logic [31:0] vn;
   logic [31:0] vm;
   logic        is_add, is_addi, is_sumc, is_sumv;
   logic        is_bt, is_bf, is_bts, is_bfs, is_bra, is_bsr, is_jmp, is_jsr;
   logic        is_braf, is_bsrf, is_rts, is_rte, is_trap, is_ldsr, is_nop;
   logic        is_branch, is_assigned, loop_bad;

   assign w  = instr.word;
   assign rn = w[11:8];
   assign rm = w[7:4];
   assign vn = gregs_r[rn];
   assign vm = gregs_r[rm];

   // pattern matches for the instructions this unit knows
   assign is_add  = match(w, `AFSC_M_RR,  `AFSC_P_ADD);
   assign is_sumc = match(w, `AFSC_M_RR,  `AFSC_P_SUMC);
   assign is_sumv = match(w, `AFSC_M_RR,  `AFSC_P_SUMV);
   assign is_addi = match(w, `AFSC_M_HI4, `AFSC_P_ADDI);
   assign is_bra  = match(w, `AFSC_M_HI4, `AFSC_P_BRA);
   assign is_bsr  = match(w, `AFSC_M_HI4, `AFSC_P_BSR);
   assign is_bt   = match(w, `AFSC_M_HI8, `AFSC_P_BT);
   assign is_bf   = match(w, `AFSC_M_HI8, `AFSC_P_BF);
   assign is_bts  = match(w, `AFSC_M_HI8, `AFSC_P_BTS);
   assign is_bfs  = match(w, `AFSC_M_HI8, `AFSC_P_BFS);
   assign is_trap = match(w, `AFSC_M_HI8, `AFSC_P_TRAP);
   assign is_jmp  = match(w, `AFSC_M_REG, `AFSC_P_JMP);
   assign is_jsr  = match(w, `AFSC_M_REG, `AFSC_P_JSR);
   assign is_braf = match(w, `AFSC_M_REG, `AFSC_P_BRAF);
   assign is_bsrf = match(w, `AFSC_M_REG, `AFSC_P_BSRF);
   assign is_ldsr = match(w, `AFSC_M_REG, `AFSC_P_LDSR) | match(w, `AFSC_M_REG, `AFSC_P_LDSRM);
   assign is_rts  = match(w, `AFSC_M_ALL, `AFSC_P_RTS);
   assign is_rte  = match(w, `AFSC_M_ALL, `AFSC_P_RTE);
   assign is_nop  = match(w, `AFSC_M_ALL, `AFSC_P_NOP);

   // every branching form counts, delayed or not
   assign is_branch = is_bt | is_bf | is_bts | is_bfs | is_bra | is_bsr | is_jmp | is_jsr
                    | is_braf | is_bsrf | is_rts | is_rte | is_trap;
   assign is_assigned = is_branch | is_add | is_sumc | is_sumv | is_addi | is_ldsr | is_nop
                      | instr.known_other;
   assign loop_bad = instr.loop_tail & (~is_assigned | is_branch | is_ldsr | instr.loop_reg_wr);

   // ----------------------------------------------------------------------------
   // exception classification
   // ----------------------------------------------------------------------------
   afsc_cause_t cause_nxt;
   logic        in_slot;

   assign in_slot = (slot_r == AFSC_SLOT_ARMED);

   // slot faults outrank loop faults, which outrank plain illegal opcodes
   always_comb begin
      cause_nxt = AFSC_CAUSE_NONE;
      if (in_slot && (is_branch || !is_assigned)) begin
         cause_nxt = AFSC_CAUSE_SLOT;
      end else if (loop_bad) begin
         cause_nxt = AFSC_CAUSE_LOOP;
      end else if (!is_assigned) begin
         cause_nxt = AFSC_CAUSE_ILLEGAL;
      end
   end

   logic do_exec;
   assign do_exec = instr.valid && (cause_nxt == AFSC_CAUSE_NONE);

   // ----------------------------------------------------------------------------
   // arithmetic
   // ----------------------------------------------------------------------------
   logic [32:0] sum_with_carry;
   logic [31:0] sum_plain;
   logic [31:0] sum_imm;
   logic        sum_with_overflow;
   logic        t_flag;

   assign t_flag = status_word_r[`AFSC_SW_T];
   assign sum_plain = vn + vm;
   assign sum_imm = vn + {{24{w[7]}}, w[7:0]};
   assign sum_with_carry = {1'b0, vn} + {1'b0, vm} + {32'h0000_0000, t_flag};
   assign sum_with_overflow = (vn[31] == vm[31]) && (sum_plain[31] != vn[31]);

   // ----------------------------------------------------------------------------
   // branch target, sampled at branch time
   // ----------------------------------------------------------------------------
   logic [31:0] br_disp8;
   logic [31:0] br_disp12;
   logic        delayed_taken;
   logic        plain_taken;
   logic [31:0] target_nxt;

   assign br_disp8  = {{23{w[7]}}, w[7:0], 1'b0};
   assign br_disp12 = {{19{w[11]}}, w[11:0], 1'b0};
   assign delayed_taken = do_exec && (is_bra || is_bsr || is_jmp || is_jsr || is_braf || is_bsrf
                          || is_rts || (is_bts && t_flag) || (is_bfs && !t_flag));
   assign plain_taken = do_exec && ((is_bt && t_flag) || (is_bf && !t_flag));

   // operands read now, so a slot that rewrites them cannot move the target
   always_comb begin
      target_nxt = pc_ahead(instr.pc) + br_disp8;
      if (is_bra || is_bsr) begin
         target_nxt = pc_ahead(instr.pc) + br_disp12;
      end else if (is_jmp || is_jsr) begin
         target_nxt = vn;
      end else if (is_braf || is_bsrf) begin
         target_nxt = pc_ahead(instr.pc) + vn;
      end else if (is_rts) begin
         target_nxt = ret_addr_r;
      end
   end

   // ----------------------------------------------------------------------------
   // slot state machine
   // ----------------------------------------------------------------------------
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         slot_r   <= AFSC_SLOT_IDLE;
         target_r <= `AFSC_WORD_RESET;
      end else if (instr.valid) begin
         unique case (slot_r)
            AFSC_SLOT_IDLE: begin
               if (delayed_taken) begin
                  slot_r   <= AFSC_SLOT_ARMED;
                  target_r <= target_nxt;
               end
            end
            AFSC_SLOT_ARMED: begin
               slot_r <= AFSC_SLOT_IDLE;
            end
         endcase
      end
   end

   // redirect fires after the slot has executed, or at once for a plain branch
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         redirect_valid_r <= 1'b0;
         redirect_pc_r    <= `AFSC_WORD_RESET;
      end else begin
         redirect_valid_r <= 1'b0;
         if (do_exec && in_slot) begin
            redirect_valid_r <= 1'b1;
            redirect_pc_r    <= target_r;
         end else if (plain_taken) begin
            redirect_valid_r <= 1'b1;
            redirect_pc_r    <= target_nxt;
         end
      end
   end

   // ----------------------------------------------------------------------------
   // exceptions and address unit
   // ----------------------------------------------------------------------------
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         exc_valid_r <= 1'b0;
         exc_cause_r <= AFSC_CAUSE_NONE;
         exc_pc_r    <= `AFSC_WORD_RESET;
      end else begin
         exc_valid_r <= instr.valid && (cause_nxt != AFSC_CAUSE_NONE);
         if (instr.valid && (cause_nxt != AFSC_CAUSE_NONE)) begin
            exc_cause_r <= cause_nxt;
            exc_pc_r    <= instr.pc;
         end
      end
   end

   // no address error is raised here; intr_block tells outer logic to hold it off
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         agu_valid_r <= 1'b0;
         agu_addr_r  <= `AFSC_WORD_RESET;
      end else begin
         agu_valid_r <= agu_req.valid;
         if (agu_req.valid) begin
            agu_addr_r <= (agu_req.pc_rel ? pc_ahead(agu_req.base) : agu_req.base)
                          + scale_disp(agu_req.disp, agu_req.size);
         end
      end
   end

   // ----------------------------------------------------------------------------
   // general registers and return address
   // ----------------------------------------------------------------------------
   logic        bus_greg;
   logic [3:0]  bus_greg_idx;

   assign bus_greg     = ((reg_addr & `AFSC_GREG_SEL_MASK) == `AFSC_OFS_GREG_BASE);
   assign bus_greg_idx = reg_addr[5:2];

   // a bus write to the same register wins over the instruction result
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         for (int i = 0; i < NUM_GREGS; i++) begin
            gregs_r[i] <= `AFSC_WORD_RESET;
         end
      end else begin
         if (do_exec) begin
            if (is_add || is_sumv) begin
               gregs_r[rn] <= sum_plain;
            end else if (is_sumc) begin
               gregs_r[rn] <= sum_with_carry[31:0];
            end else if (is_addi) begin
               gregs_r[rn] <= sum_imm;
            end
         end
         if (reg_wr && bus_greg) begin
            gregs_r[bus_greg_idx] <= reg_wdata;
         end
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ret_addr_r <= `AFSC_WORD_RESET;
      end else if (reg_wr && reg_addr == `AFSC_OFS_RET_ADDR) begin
         ret_addr_r <= reg_wdata;
      end else if (delayed_taken && (is_bsr || is_jsr || is_bsrf)) begin
         ret_addr_r <= pc_ahead(instr.pc);
      end
   end

   // ----------------------------------------------------------------------------
   // status word
   // ----------------------------------------------------------------------------
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         status_word_r <= `AFSC_SW_RESET;
      end else if (reg_wr && reg_addr == `AFSC_OFS_STATUS_WORD) begin
         status_word_r <= reg_wdata & `AFSC_SW_WMASK;
      end else if (do_exec && is_sumc) begin
         status_word_r[`AFSC_SW_T] <= sum_with_carry[32];
      end else if (do_exec && is_sumv) begin
         status_word_r[`AFSC_SW_T] <= sum_with_overflow;
      end
   end

   // ----------------------------------------------------------------------------
   // events, mask and interrupt
   // ----------------------------------------------------------------------------
   logic [`AFSC_EVT_W-1:0] evt_set;

   assign evt_set[`AFSC_EVT_ILLEGAL] = instr.valid && (cause_nxt == AFSC_CAUSE_ILLEGAL);
   assign evt_set[`AFSC_EVT_SLOT]    = instr.valid && (cause_nxt == AFSC_CAUSE_SLOT);
   assign evt_set[`AFSC_EVT_LOOP]    = instr.valid && (cause_nxt == AFSC_CAUSE_LOOP);
   assign evt_set[`AFSC_EVT_OVF]     = do_exec && is_sumv && sum_with_overflow;

   // set beats a write-one clear in the same cycle
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         evt_status_r <= `AFSC_EVT_RESET;
      end else begin
         evt_status_r <= (evt_status_r & ~((reg_wr && reg_addr == `AFSC_OFS_EVT_STATUS) ?
                          reg_wdata[`AFSC_EVT_W-1:0] : `AFSC_EVT_RESET)) | evt_set;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         evt_mask_r <= `AFSC_EVT_RESET;
      end else if (reg_wr && reg_addr == `AFSC_OFS_EVT_MASK) begin
         evt_mask_r <= reg_wdata[`AFSC_EVT_W-1:0];
      end
   end

   // the pending-slot window holds the interrupt back; it shows as intr_block
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= |(evt_status_r & evt_mask_r) && !(slot_r == AFSC_SLOT_ARMED);
      end
   end

   // ----------------------------------------------------------------------------
   // register read port, data one cycle after the strobe
   // ----------------------------------------------------------------------------
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         reg_rdata_r <= `AFSC_WORD_RESET;
      end else if (reg_rd) begin
         if (bus_greg) begin
            reg_rdata_r <= gregs_r[bus_greg_idx];
         end else begin
            unique case (reg_addr)
               `AFSC_OFS_STATUS_WORD: reg_rdata_r <= status_word_r;
               `AFSC_OFS_EVT_STATUS:  reg_rdata_r <= {28'h000_0000, evt_status_r};
               `AFSC_OFS_EVT_MASK:    reg_rdata_r <= {28'h000_0000, evt_mask_r};
               `AFSC_OFS_EXC_PC:      reg_rdata_r <= exc_pc_r;
               `AFSC_OFS_RET_ADDR:    reg_rdata_r <= ret_addr_r;
               default:               reg_rdata_r <= `AFSC_WORD_RESET; // unmapped reads zero
            endcase
         end
      end else begin
         reg_rdata_r <= `AFSC_WORD_RESET;
      end
   end

   // ----------------------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------------------
   assign reg_rdata      = reg_rdata_r;
   assign irq            = irq_r;
   assign redirect_valid = redirect_valid_r;
   assign redirect_pc    = redirect_pc_r;
   assign exc_valid      = exc_valid_r;
   assign exc_cause      = exc_cause_r;
   assign exc_pc         = exc_pc_r;
   assign intr_block     = slot_r;
   assign agu_valid      = agu_valid_r;
   assign agu_addr       = agu_addr_r;

endmodule : afsc_core

// ---- verification/afsc_core_properties.sv ----
/* concurrent checks on afsc_core ports: slot handling, exceptions, address unit.
   assumes a bind onto afsc_core and the single clk domain with async reset. */
`timescale 1ns/1ps
`include "afsc_defines.svh"
module afsc_core_properties (
   input wire logic                    clk,
   input wire logic                    reset,
   input wire afsc_pkg::afsc_instr_t   instr,
   input wire afsc_pkg::afsc_agu_req_t agu_req,
   input wire logic                    redirect_valid,
   input wire logic                    exc_valid,
   input wire afsc_pkg::afsc_cause_t   exc_cause,
   input wire logic [31:0]             exc_pc,
   input wire logic                    intr_block,
   input wire logic                    agu_valid,
   input wire logic [31:0]             agu_addr
);
   import afsc_pkg::*;
   // address expected from the request alone, scaled by operand size
   wire logic [31:0] agu_exp = agu_req.base + (agu_req.pc_rel ? `AFSC_PC_AHEAD : 32'h0)
                               + ({24'h0, agu_req.disp} << (agu_req.size[1] ? 2'd2 : agu_req.size));
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // ---------------------------------------------------------------
   // delayed branch steps, exceptions and address unit
   // ---------------------------------------------------------------
   sequence s_bra;
      !intr_block && instr.valid && !instr.loop_tail && (instr.word & `AFSC_M_HI4) == `AFSC_P_BRA;
   endsequence
   sequence s_slot_ok;
      intr_block && instr.valid && ((instr.word & `AFSC_M_HI4) == `AFSC_P_ADDI
                                    || (instr.word & `AFSC_M_RR) == `AFSC_P_ADD);
   endsequence
   sequence s_slot_bad;
      intr_block && instr.valid && (instr.word & `AFSC_M_HI4) == `AFSC_P_BRA;
   endsequence
   AST_BRA_ARM: assert property (s_bra |=> intr_block && !redirect_valid)
      else $error("branch did not wait for its slot");
   AST_SLOT_HOLD: assert property (intr_block && !instr.valid |=> intr_block)
      else $error("slot window closed without a slot");
   AST_SLOT_RUN: assert property (s_slot_ok |=> redirect_valid && !exc_valid && !intr_block)
      else $error("slot ran without redirect");
   AST_SLOT_BAD: assert property (s_slot_bad |=> exc_valid && exc_cause == AFSC_CAUSE_SLOT
                                  && exc_pc == $past(instr.pc) && !redirect_valid)
      else $error("branch in slot not refused");
   AST_ILL: assert property (!intr_block && instr.valid && !instr.loop_tail && instr.word == `AFSC_M_ALL
                             |=> exc_valid && exc_cause == AFSC_CAUSE_ILLEGAL)
      else $error("unassigned opcode not refused");
   AST_LOOP: assert property (!intr_block && instr.valid && instr.loop_tail && instr.loop_reg_wr
                              |=> exc_valid && exc_cause == AFSC_CAUSE_LOOP)
      else $error("loop tail writer not refused");
   AST_QUIET: assert property (!instr.valid |=> !exc_valid && !redirect_valid)
      else $error("event without instruction");
   AST_AGU: assert property (agu_req.valid |=> agu_valid && agu_addr == $past(agu_exp))
      else $error("address unit result wrong");
   AST_AGU_IDLE: assert property (!agu_req.valid |=> !agu_valid)
      else $error("address unit pulse without request");
endmodule : afsc_core_properties

bind afsc_core afsc_core_properties u_props (.clk(clk), .reset(reset), .instr(instr), .agu_req(agu_req),
   .redirect_valid(redirect_valid), .exc_valid(exc_valid), .exc_cause(exc_cause), .exc_pc(exc_pc),
   .intr_block(intr_block), .agu_valid(agu_valid), .agu_addr(agu_addr));

// ---- verification/testbench.sv ----
/* self-checking bench for afsc_core: register port tasks and instruction sequences.
   assumes afsc_pkg compiled first and afsc_defines.svh on the include path. */
`timescale 1ns/1ps
`include "afsc_defines.svh"
module testbench;
   import afsc_pkg::*;
   logic          clk, reset, reg_wr, reg_rd, irq, redirect_valid, exc_valid, intr_block, agu_valid;
   logic [7:0]    reg_addr;
   logic [31:0]   reg_wdata, reg_rdata, redirect_pc, exc_pc, agu_addr;
   afsc_instr_t   instr;
   afsc_agu_req_t agu_req;
   afsc_cause_t   exc_cause;
   int            errors, n_tests, cyc;
   // every branch kind that may not sit in a slot, plus an unassigned word
   logic [15:0]   slot_bad [14] = '{`AFSC_P_BT, `AFSC_P_BF, `AFSC_P_BRA, `AFSC_P_BSR, `AFSC_P_JMP,
      `AFSC_P_JSR, `AFSC_P_RTS, `AFSC_P_RTE, `AFSC_P_TRAP, `AFSC_P_BTS, `AFSC_P_BFS, `AFSC_P_BRAF,
      `AFSC_P_BSRF, 16'hffff};

   afsc_core dut (.clk(clk), .reset(reset), .instr(instr), .agu_req(agu_req), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
      .redirect_valid(redirect_valid), .redirect_pc(redirect_pc), .exc_valid(exc_valid),
      .exc_cause(exc_cause), .exc_pc(exc_pc), .intr_block(intr_block), .agu_valid(agu_valid),
      .agu_addr(agu_addr));

   always #4 clk = ~clk;
   // hang guard: the sequence needs well under this many cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         errors++;
         finish_test();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk) begin
         reg_wr <= 1'b1;
         instr.valid <= 1'b0;
         reg_addr <= a;
         reg_wdata <= d;
      end
      @(posedge clk) reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk) begin
         reg_rd <= 1'b1;
         instr.valid <= 1'b0;
         reg_addr <= a;
      end
      @(posedge clk) reg_rd <= 1'b0;
      #1 chk(reg_rdata, exp);
   endtask : rd
   // flags are known_other, loop_reg_wr, loop_tail; held until a bus task, exc, red or the next iss replaces it
   task automatic iss(input logic [15:0] w, input logic [31:0] pc, input logic [2:0] f);
      @(posedge clk) instr <= {1'b1, w, pc, f};
   endtask : iss
   task automatic exc(input logic [1:0] c, input logic [31:0] pc);
      @(posedge clk) instr <= '0;
      #1 chk(exc_valid, 32'h1);
      chk(exc_cause, c);
      chk(exc_pc, pc);
   endtask : exc
   task automatic red(input logic [31:0] pc);
      @(posedge clk) instr <= '0;
      #1 chk(redirect_valid, 32'h1);
      chk(redirect_pc, pc);
   endtask : red
   task automatic finish_test;
      $display("errors %0d, comparisons %0d", errors, n_tests);
      if (errors == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : finish_test

   initial begin
      {clk, reset, reg_wr, reg_rd, reg_addr, reg_wdata, instr, agu_req} = '0;
      reset = 1'b1;
      {errors, n_tests, cyc} = '0;
      repeat (4) @(posedge clk);
      reset <= 1'b0;
      rd(8'h00, 32'h0000_00f0);
      rd(8'h3c, 32'h0);
      wr(8'h00, 32'hffff_ffff);
      rd(8'h00, 32'h0fff_0fff);
      // two back-to-back adds, flag set beforehand must survive
      wr(8'h40, 32'h7fff_ffff);
      wr(8'h44, 32'h1);
      iss(16'h310c, 32'h0, 3'b0);
      iss(16'h310c, 32'h2, 3'b0);
      wr(8'h4c, 32'h1);
      rd(8'h44, 32'hffff_ffff);
      rd(8'h00, 32'h0fff_0fff);
      iss(16'h73fe, 32'h4, 3'b0);
      iss(16'h737f, 32'h6, 3'b0);
      wr(8'h00, 32'h0);
      rd(8'h4c, 32'h7e);
      // carry chain: second add consumes the carry of the first
      wr(8'h44, 32'h1);
      wr(8'h4c, 32'hffff_ffff);
      wr(8'h40, 32'h0);
      wr(8'h48, 32'h0);
      iss(16'h313e, 32'h8, 3'b0);
      iss(16'h302e, 32'ha, 3'b0);
      rd(8'h40, 32'h1);
      wr(8'h40, 32'h2);
      rd(8'h44, 32'h0);
      rd(8'h00, 32'h0);
      wr(8'h44, 32'h7fff_fffe);
      iss(16'h310f, 32'hc, 3'b0);
      wr(8'h08, 32'h8);
      rd(8'h44, 32'h8000_0000);
      rd(8'h00, 32'h1);
      chk(irq, 32'h1);
      iss(16'h310f, 32'he, 3'b0);
      wr(8'h04, 32'h8);
      rd(8'h00, 32'h0);
      chk(irq, 32'h0);
      iss(16'hffff, 32'h100, 3'b0);
      exc(AFSC_CAUSE_ILLEGAL, 32'h100);
      rd(8'h04, 32'h1);
      iss(16'ha010, 32'h200, 3'b0);
      iss(16'h310c, 32'h202, 3'b0);
      red(32'h224);
      rd(8'h44, 32'h8000_0004);
      // slot overwrites the jump register; a gap sits between jump and slot
      wr(8'h50, 32'h1000);
      iss(16'h442b, 32'h300, 3'b0);
      @(posedge clk) instr.valid <= 1'b0;
      iss(16'h7404, 32'h302, 3'b0);
      red(32'h1000);
      rd(8'h50, 32'h1004);
      iss(16'h8b05, 32'h600, 3'b0);
      red(32'h60e);
      foreach (slot_bad[i]) begin
         iss(`AFSC_P_BRA, 32'h400, 3'b0);
         iss(slot_bad[i], 32'h402, 3'b0);
         exc(AFSC_CAUSE_SLOT, 32'h402);
      end
      iss(`AFSC_P_LDSR, 32'h500, 3'b011);
      exc(AFSC_CAUSE_LOOP, 32'h500);
      @(posedge clk) agu_req <= {1'b1, 32'h1000, 8'h81, 2'd1, 1'b0};
      @(posedge clk) agu_req <= {1'b1, 32'h1000, 8'h81, 2'd2, 1'b1};
      @(posedge clk) agu_req.valid <= 1'b0;
      #1 chk(agu_addr, 32'h1208);
      finish_test();
   end
endmodule : testbench
